// ---- rtl/lipu_defs.svh ----
// register offsets, field positions and reset values of the local interrupt priority unit
`ifndef LIPU_DEFS_SVH
`define LIPU_DEFS_SVH
`define LIPU_OFF_ID 12'h020
`define LIPU_OFF_TPT 12'h080
`define LIPU_OFF_PPL 12'h0A0
`define LIPU_OFF_EOS 12'h0B0
`define LIPU_OFF_LTR 12'h0D0
`define LIPU_OFF_TFR 12'h0E0
`define LIPU_OFF_ERR 12'h280
`define LIPU_OFF_CMDLO 12'h300
`define LIPU_OFF_CMDHI 12'h310
`define LIPU_OFF_CTRL 12'h3F0
`define LIPU_OFF_PEND 12'h200
`define LIPU_OFF_INSV 12'h100
`define LIPU_OFF_TRIG 12'h180
`define LIPU_CMD_VEC_LSB 0
`define LIPU_CMD_TRIG_BIT 15
`define LIPU_CMD_MODE_BIT 11
`define LIPU_CMD_SH_LSB 18
`define LIPU_CMD_PID_LSB 56
`define LIPU_CMD_LDST_LSB 56
`define LIPU_SH_SELF 2'h1
`define LIPU_SH_NONE 2'h0
`define LIPU_ERR_SEND_BIT 5
`define LIPU_ERR_RECV_BIT 6
`define LIPU_TFR_RESET 32'hFFFFFFFF
`define LIPU_ILLEGAL_MAX 8'h0F
`define LIPU_CLASS_DEPTH 2
`endif

// ---- rtl/lipu_pkg.sv ----
// types of the local interrupt priority unit
package lipu_pkg;
  typedef enum logic [1:0] {
    LIPU_DM_PHYS = 2'b00,
    LIPU_DM_LOG = 2'b01
  } lipu_mode_t;
  typedef enum logic [1:0] {
    LIPU_BUS_IDLE = 2'b00,
    LIPU_BUS_DATA = 2'b01
  } lipu_bus_t;
endpackage

// ---- rtl/lipu_core.sv ----
// local interrupt priority unit: request queues, priority dispatch and command register
// Operation
// - 64-bit command register; self shorthand delivers the vector to this core.
// - no delivery to other cores; only self-directed commands are delivered.
// - destination mode bit: 0 selects physical, 1 selects logical.
// - physical mode takes the target identifier from command bits 59..56.
// - logical mode matches the 8-bit target against format and logical registers.
// - priority class is vector divided by 16, 1 lowest, 15 highest.
// - vectors 0..15 reserved; user interrupts use classes 1..15.
// - dispatch only above threshold; 0 admits all, 15 blocks all.
// - processor priority is max of top in-service class and threshold.
// - request and in-service arrays of 256 bits, vectors 0..15 reserved.
// - accepted fixed interrupt sets its request bit.
// - core ready: move top request bit to in-service and deliver vector.
// - end-of-service write clears the top in-service bit.
// - a vector may sit in both arrays; at most two per class.
// - a higher arrival preempts the running handler when core enables interrupts.
// - trigger bit cleared for edge sources, set for level sources on entry.
// - end of service of a level vector broadcasts an end message outward.
// - non-maskable, management and external delivery types are not supported.
// - vector 0..15 sent or received records an illegal-vector error.
`include "lipu_defs.svh"
module lipu_core
  import lipu_pkg::*;
#(
  parameter logic [3:0] CTRL_ID = 4'h0,
  parameter int VEC_N = 256
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // fixed interrupt arrivals, from core-clock logic
  input wire logic irqValid,
  input wire logic [7:0] irqVector,
  input wire logic irqLevel,
  // processor core
  input wire logic coreReady,
  input wire logic coreIntEnable,
  output logic dispatchValid,
  output logic [7:0] dispatchVector,
  // end-of-service broadcast to external controllers
  output logic endMsgValid,
  output logic [7:0] endMsgVector
);
  logic [VEC_N-1:0] pendingRequestBits_reg;
  logic [VEC_N-1:0] inServiceBits_reg;
  logic [VEC_N-1:0] triggerKindBits_reg;
  logic [3:0] taskPriorityThreshold_reg;
  logic [31:0] logicalTargetReg_reg;
  logic [31:0] targetFormatReg_reg;
  logic [31:0] errorRecordReg_reg;
  logic [63:0] interruptCommandReg_reg;
  logic [31:0] ctrl_reg;
  lipu_bus_t busState_reg;
  logic [11:0] busAddr_reg;
  logic busWrite_reg;

  // highest set bit index of a 256-bit array; valid flag in bit 8
  // scans upward so the last hit wins: the highest vector is the highest priority
  function automatic logic [8:0] topBit(input logic [VEC_N-1:0] bits);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 0; i < VEC_N; i++) begin
      if (bits[i]) begin
        r = {1'b1, 8'(i)};
      end
    end
    return r;
  endfunction

  // class is the upper nibble of the vector
  // vectors 0..15 map to class 0, which never beats any threshold
  function automatic logic [3:0] classOf(input logic [7:0] v);
    return v[7:4];
  endfunction

  // count of queued entries of one class across both arrays
  // pending and in-service copies both take a slot of the two-deep class
  function automatic logic [5:0] classCount(input logic [VEC_N-1:0] a,
                                            input logic [VEC_N-1:0] b,
                                            input logic [3:0] c);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + 6'(a[{c, 4'(i)}]) + 6'(b[{c, 4'(i)}]);
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // priority evaluation
  logic [8:0] topReq;
  logic [8:0] topSvc;
  logic [3:0] svcClass;
  logic [3:0] processorPriorityLevel;
  logic canDispatch;
  assign topReq = topBit(pendingRequestBits_reg);
  assign topSvc = topBit(inServiceBits_reg);
  assign svcClass = topSvc[8] ? classOf(topSvc[7:0]) : 4'h0;
  // larger of top in-service class and threshold
  // combinational, so a retire is seen by the very next dispatch decision
  assign processorPriorityLevel = (svcClass > taskPriorityThreshold_reg) ? svcClass :
                                  taskPriorityThreshold_reg;
  // strict greater-than; threshold 15 blocks every class
  // an in-service handler raises the bar to its own class, so only higher classes preempt it
  // control bit 0 gates every dispatch; clearing it quiets the unit without losing requests
  assign canDispatch = topReq[8] && coreReady && coreIntEnable && ctrl_reg[0] &&
                       (classOf(topReq[7:0]) > processorPriorityLevel);

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: writes finish in one data cycle, reads add one wait state
  // sequential transfers are taken like plain ones; only single words are expected
  logic addrTake;
  logic busWr;
  logic busRd;
  logic busWord_reg;
  assign addrTake = hsel && hready && htrans[1];
  // narrow writes are dropped: every register is one whole word
  assign busWr = (busState_reg == LIPU_BUS_DATA) && busWrite_reg && busWord_reg;
  assign busRd = (busState_reg == LIPU_BUS_DATA) && !busWrite_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busState_reg <= LIPU_BUS_IDLE;
      busAddr_reg <= 12'h000;
      busWrite_reg <= 1'b0;
      busWord_reg <= 1'b0;
    end else if (hready) begin
      // the address is latched on every ready edge; only busState_reg says it counts
      busState_reg <= addrTake ? LIPU_BUS_DATA : LIPU_BUS_IDLE;
      busAddr_reg <= haddr;
      busWrite_reg <= hwrite;
      busWord_reg <= (hsize == 3'h2);
    end
  end

  logic wrEos;
  logic wrCmdLo;
  assign wrEos = busWr && (busAddr_reg == `LIPU_OFF_EOS);
  assign wrCmdLo = busWr && (busAddr_reg == `LIPU_OFF_CMDLO);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      taskPriorityThreshold_reg <= 4'h0;
      logicalTargetReg_reg <= 32'h00000000;
      targetFormatReg_reg <= `LIPU_TFR_RESET;
      interruptCommandReg_reg <= 64'h0000000000000000;
      ctrl_reg <= 32'h00000001;
    end else if (busWr) begin
      // the logical register keeps its top byte; the format register's low bits stay ones
      case (busAddr_reg)
        `LIPU_OFF_TPT: taskPriorityThreshold_reg <= hwdata[3:0];
        `LIPU_OFF_LTR: logicalTargetReg_reg <= {hwdata[31:24], 24'h000000};
        `LIPU_OFF_TFR: targetFormatReg_reg <= {hwdata[31:28], 28'hFFFFFFF};
        `LIPU_OFF_CMDLO: interruptCommandReg_reg[31:0] <= hwdata;
        `LIPU_OFF_CMDHI: interruptCommandReg_reg[63:32] <= hwdata;
        `LIPU_OFF_CTRL: ctrl_reg <= {31'h00000000, hwdata[0]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command decode: writing the low word issues the command
  // the high word must be written first; the low word is used straight from the bus
  logic [63:0] cmdNow;
  logic [7:0] cmdVec;
  logic [1:0] cmdShort;
  logic cmdLogical;
  logic [7:0] targetAddr;
  logic targetHit;
  logic selfIssue;
  assign cmdNow = {interruptCommandReg_reg[63:32], hwdata};
  assign cmdVec = cmdNow[`LIPU_CMD_VEC_LSB +: 8];
  assign cmdShort = cmdNow[`LIPU_CMD_SH_LSB +: 2];
  assign cmdLogical = cmdNow[`LIPU_CMD_MODE_BIT];
  assign targetAddr = cmdNow[`LIPU_CMD_LDST_LSB +: 8];

  // flat model uses a bitmask, cluster model matches cluster and member bits
  function automatic logic logicalMatch(input logic [7:0] mta, input logic [31:0] fmt,
                                        input logic [31:0] ltr);
    logic m;
    if (fmt[31:28] == 4'hF) begin
      m = |(mta & ltr[31:24]);
    end else begin
      m = (mta[7:4] == ltr[31:28]) && |(mta[3:0] & ltr[27:24]);
    end
    return m;
  endfunction

  always_comb begin
    if (cmdLogical) begin
      targetHit = logicalMatch(targetAddr, targetFormatReg_reg, logicalTargetReg_reg);
    end else begin
      targetHit = (cmdNow[`LIPU_CMD_PID_LSB +: 4] == CTRL_ID);
    end
  end

  // self shorthand always lands here; explicit targets only if they name us
  assign selfIssue = wrCmdLo && ((cmdShort == `LIPU_SH_SELF) ||
                                 ((cmdShort == `LIPU_SH_NONE) && targetHit));

  ////////////////////////////////////////////////////////////////////////////////
  // arrivals: the command path wins over the pin path in the same cycle
  logic arrValid;
  logic [7:0] arrVec;
  logic arrLevel;
  logic arrLegal;
  logic arrRoom;
  logic arrTake;
  // only fixed delivery exists, so every arrival meets threshold and end of service
  assign arrValid = selfIssue || irqValid;
  assign arrVec = selfIssue ? cmdVec : irqVector;
  assign arrLevel = selfIssue ? cmdNow[`LIPU_CMD_TRIG_BIT] : irqLevel;
  assign arrLegal = arrVec > `LIPU_ILLEGAL_MAX;
  // at most two per class; a vector may already sit in service
  assign arrRoom = classCount(pendingRequestBits_reg, inServiceBits_reg, classOf(arrVec)) <
                   6'(`LIPU_CLASS_DEPTH);
  // an illegal or overfull arrival is dropped and leaves the trigger bits alone
  assign arrTake = arrValid && arrLegal && arrRoom;

  logic eosHit;
  assign eosHit = wrEos && topSvc[8];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pendingRequestBits_reg <= '0;
    end else begin
      if (canDispatch) begin
        pendingRequestBits_reg[topReq[7:0]] <= 1'b0;
      end
      // a same-cycle arrival of the dispatched vector queues it again: the set comes last
      if (arrTake) begin
        pendingRequestBits_reg[arrVec] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      inServiceBits_reg <= '0;
    end else begin
      if (eosHit) begin
        inServiceBits_reg[topSvc[7:0]] <= 1'b0;
      end
      // dispatch of the vector being retired keeps it in service
      if (canDispatch) begin
        inServiceBits_reg[topReq[7:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      triggerKindBits_reg <= '0;
    end else if (arrTake) begin
      triggerKindBits_reg[arrVec] <= arrLevel;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dispatchValid <= 1'b0;
      dispatchVector <= 8'h00;
    end else begin
      // the vector holds after the pulse so a slow core can still read it
      dispatchValid <= canDispatch;
      if (canDispatch) begin
        dispatchVector <= topReq[7:0];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      endMsgValid <= 1'b0;
      endMsgVector <= 8'h00;
    end else begin
      // trigger bits outlive service, so the retiring vector's kind is still known
      endMsgValid <= eosHit && triggerKindBits_reg[topSvc[7:0]];
      if (eosHit) begin
        endMsgVector <= topSvc[7:0];
      end
    end
  end

  // sticky; a new error in the clearing write survives it
  logic errSend;
  logic errRecv;
  assign errSend = selfIssue && !arrLegal;
  // a pin arrival lost to a same-cycle command is neither queued nor reported
  assign errRecv = irqValid && !selfIssue && (irqVector <= `LIPU_ILLEGAL_MAX);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      errorRecordReg_reg <= 32'h00000000;
    end else begin
      if (busWr && (busAddr_reg == `LIPU_OFF_ERR)) begin
        errorRecordReg_reg <= 32'h00000000;
      end
      if (errSend) begin
        errorRecordReg_reg[`LIPU_ERR_SEND_BIT] <= 1'b1;
      end
      if (errRecv) begin
        errorRecordReg_reg[`LIPU_ERR_RECV_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux; arrays read in eight words from their base, 16 bytes apart
  // a window is eight words at 16-byte steps from an array's base
  function automatic logic inWindow(input logic [11:0] a, input logic [11:0] base);
    return (a[3:0] == 4'h0) && (a[11:7] == base[11:7]);
  endfunction

  logic [31:0] rdMux;
  logic [2:0] arrWord;
  assign arrWord = busAddr_reg[6:4];
  always_comb begin
    // unmapped offsets read as zero
    rdMux = 32'h00000000;
    case (busAddr_reg)
      `LIPU_OFF_ID: rdMux = {4'h0, CTRL_ID, 24'h000000};
      `LIPU_OFF_TPT: rdMux = {28'h0000000, taskPriorityThreshold_reg};
      `LIPU_OFF_PPL: rdMux = {28'h0000000, processorPriorityLevel};
      `LIPU_OFF_LTR: rdMux = logicalTargetReg_reg;
      `LIPU_OFF_TFR: rdMux = targetFormatReg_reg;
      `LIPU_OFF_ERR: rdMux = errorRecordReg_reg;
      `LIPU_OFF_CMDLO: rdMux = interruptCommandReg_reg[31:0];
      `LIPU_OFF_CMDHI: rdMux = interruptCommandReg_reg[63:32];
      `LIPU_OFF_CTRL: rdMux = ctrl_reg;
      default: begin
        if (inWindow(busAddr_reg, `LIPU_OFF_INSV)) begin
          rdMux = inServiceBits_reg[{arrWord, 5'h00} +: 32];
        end else if (inWindow(busAddr_reg, `LIPU_OFF_TRIG)) begin
          rdMux = triggerKindBits_reg[{arrWord, 5'h00} +: 32];
        end else if (inWindow(busAddr_reg, `LIPU_OFF_PEND)) begin
          rdMux = pendingRequestBits_reg[{arrWord, 5'h00} +: 32];
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // a read waits one cycle: its data loads in the wait and stands in the final cycle,
      // after any write that ended at the read's address phase has landed
      hreadyout <= !(addrTake && !hwrite);
      hresp <= 1'b0;
      if (busRd && !hreadyout) begin
        hrdata <= rdMux;
      end
    end
  end
endmodule

// ---- test/lipu_core_properties.sv ----
// concurrent checks on the ports of the local interrupt priority unit
`include "lipu_defs.svh"
module lipu_core_checker
  import lipu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // core side
  input wire logic coreReady,
  input wire logic coreIntEnable,
  input wire logic dispatchValid,
  input wire logic [7:0] dispatchVector,
  input wire logic endMsgValid,
  input wire logic [7:0] endMsgVector
);
  logic tptWr;
  logic [3:0] tptShadow;
  logic [2:0] sinceEos;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) tptWr <= 1'b0;
    else tptWr <= hsel && hready && htrans[1] && hwrite && haddr == `LIPU_OFF_TPT;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) tptShadow <= 4'h0;
    else if (tptWr && hready) tptShadow <= hwdata[3:0];
  end
  // saturates so an old write never excuses a late broadcast
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) sinceEos <= 3'h7;
    else if (hsel && hready && htrans[1] && hwrite && haddr == `LIPU_OFF_EOS) sinceEos <= 3'h0;
    else if (sinceEos != 3'h7) sinceEos <= sinceEos + 3'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  dispatch_ready_a: assert property (dispatchValid |-> $past(coreReady && coreIntEnable))
    else $error("dispatch without a ready core");
  dispatch_vector_a: assert property (dispatchValid |-> dispatchVector > `LIPU_ILLEGAL_MAX)
    else $error("illegal vector dispatched");
  above_threshold_a: assert property (dispatchValid |-> dispatchVector[7:4] > $past(tptShadow))
    else $error("dispatch not above threshold");
  threshold_block_a: assert property ($past(tptShadow) == 4'hF |-> !dispatchValid)
    else $error("dispatch under full threshold");
  endmsg_cause_a: assert property (endMsgValid |-> sinceEos <= 3'h3)
    else $error("end message without end of service");
  endmsg_vector_a: assert property (endMsgValid |-> endMsgVector > `LIPU_ILLEGAL_MAX)
    else $error("end message with illegal vector");
  bus_ready_a: assert property (!hreadyout |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("wait state without a read");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=>
                                !hreadyout ##1 hreadyout)
    else $error("read without its single wait state");
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("error response");
  cover property (dispatchValid && dispatchVector[7:4] == 4'hF);
  cover property (dispatchValid && tptShadow != 4'h0);
  cover property (endMsgValid);
  cover property (!hreadyout);
endmodule
bind lipu_core lipu_core_checker i_lipu_core_checker (.clock(clock), .arst_n(arst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .coreReady(coreReady),
  .coreIntEnable(coreIntEnable), .dispatchValid(dispatchValid),
  .dispatchVector(dispatchVector), .endMsgValid(endMsgValid), .endMsgVector(endMsgVector));

// ---- test/lipu_core_model.sv ----
// behavioural processor core that takes dispatched vectors
module lipu_core_model
  import lipu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // bench control
  input wire logic stall,
  input wire logic intOn,
  // dispatch side
  input wire logic dispatchValid,
  input wire logic [7:0] dispatchVector,
  output logic coreReady,
  output logic coreIntEnable,
  // record of taken vectors
  output logic [7:0] takenVec,
  output int takenCnt
);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      coreReady <= 1'b0;
      coreIntEnable <= 1'b0;
    end else begin
      coreReady <= !stall;
      coreIntEnable <= intOn;
    end
  end
  // every pulse counts, so a doubled dispatch shows up
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      takenVec <= 8'h00;
      takenCnt <= 0;
    end else if (dispatchValid === 1'b1) begin
      takenVec <= dispatchVector;
      takenCnt <= takenCnt + 1;
    end
  end
endmodule

// ---- test/test_local_interrupt_priority_unit.sv ----
// self-checking bench of the local interrupt priority unit
`include "lipu_defs.svh"
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
module test_local_interrupt_priority_unit
  import lipu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] tpt; logic [7:0] vec; logic lvl; logic now; logic ok;} lipu_row_t;
  logic clock = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, irqValid = 1'b0;
  logic irqLevel = 1'b0, stall = 1'b0, intOn = 1'b1;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hready, hreadyout, hresp, coreReady, coreIntEnable, dispatchValid, endMsgValid;
  logic [7:0] irqVector = 8'h00, dispatchVector, endMsgVector, takenVec, lastEnd;
  int errors = 0, nCompared = 0, takenCnt, nEnd = 0, c0, e0;
  lipu_row_t rows[7] = '{'{4'h0, 8'h20, 1'b0, 1'b1, 1'b1}, '{4'h3, 8'h35, 1'b1, 1'b0, 1'b1},
    '{4'h2, 8'h35, 1'b1, 1'b1, 1'b1}, '{4'hF, 8'hF0, 1'b0, 1'b0, 1'b1},
    '{4'hE, 8'hFF, 1'b1, 1'b1, 1'b1}, '{4'h0, 8'h10, 1'b0, 1'b1, 1'b1},
    '{4'h0, 8'h0F, 1'b0, 1'b0, 1'b0}};
  logic [11:0] rstAddr[5] = '{`LIPU_OFF_TFR, `LIPU_OFF_TPT, `LIPU_OFF_PPL, `LIPU_OFF_ERR, 12'h040};
  logic [31:0] rstVal[5] = '{`LIPU_TFR_RESET, 32'h0, 32'h0, 32'h0, 32'h0};
  assign hready = hreadyout;
  always #2 clock = ~clock;
  lipu_core i_lipu_core (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irqValid(irqValid),
    .irqVector(irqVector), .irqLevel(irqLevel), .coreReady(coreReady),
    .coreIntEnable(coreIntEnable), .dispatchValid(dispatchValid),
    .dispatchVector(dispatchVector), .endMsgValid(endMsgValid), .endMsgVector(endMsgVector));
  lipu_core_model i_lipu_core_model (.clock(clock), .arst_n(arst_n), .stall(stall),
    .intOn(intOn), .dispatchValid(dispatchValid), .dispatchVector(dispatchVector),
    .coreReady(coreReady), .coreIntEnable(coreIntEnable), .takenVec(takenVec),
    .takenCnt(takenCnt));
  always @(posedge clock) begin
    if (endMsgValid === 1'b1) begin
      nEnd++;
      lastEnd = endMsgVector;
    end
  end
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask
  // read data is taken at the edge that ends the data phase, after the slave's wait state
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask
  task automatic irq(input logic [7:0] v, input logic lvl);
    irqValid <= 1'b1;
    irqVector <= v;
    irqLevel <= lvl;
    @(posedge clock);
    irqValid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic waitTake(input int cnt, input bit must);
    for (int n = 0; n < 16 && takenCnt != cnt; n++) @(posedge clock);
    if (must && takenCnt != cnt) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic eos();
    bus(1'b1, `LIPU_OFF_EOS, 32'h0);
    repeat (4) @(posedge clock);
  endtask
  task automatic doReset();
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
  endtask
  initial begin
    doReset();
    foreach (rows[i]) begin
      bus(1'b1, `LIPU_OFF_TPT, {28'h0, rows[i].tpt});
      c0 = takenCnt;
      e0 = nEnd;
      irq(rows[i].vec, rows[i].lvl);
      waitTake(c0 + 1, rows[i].now);
      `CHK(takenCnt, c0 + int'(rows[i].now))
      bus(1'b1, `LIPU_OFF_TPT, 32'h0);
      waitTake(c0 + 1, rows[i].ok);
      `CHK(takenCnt, c0 + int'(rows[i].ok))
      if (rows[i].ok) begin
        `CHK(takenVec, rows[i].vec)
        eos();
        `CHK(nEnd, e0 + int'(rows[i].lvl))
        if (rows[i].lvl) `CHK(lastEnd, rows[i].vec)
      end
      $display("row %0d done", i);
    end
    bus(1'b0, `LIPU_OFF_ERR, 32'h0);
    `CHK(rd[`LIPU_ERR_RECV_BIT], 1'b1)
    doReset();
    bus(1'b1, `LIPU_OFF_PPL, 32'h0000000F);
    foreach (rstAddr[i]) begin
      bus(1'b0, rstAddr[i], 32'h0);
      `CHK(rd, rstVal[i])
    end
    $display("reset test done");
    c0 = takenCnt;
    irq(8'h40, 1'b0);
    waitTake(c0 + 1, 1'b1);
    bus(1'b0, `LIPU_OFF_PPL, 32'h0);
    `CHK(rd, 32'h4)
    bus(1'b1, `LIPU_OFF_TPT, 32'h2);
    irq(8'h30, 1'b0);
    irq(8'h90, 1'b0);
    waitTake(c0 + 2, 1'b1);
    `CHK(takenVec, 8'h90)
    eos();
    `CHK(takenCnt, c0 + 2)
    bus(1'b0, `LIPU_OFF_PPL, 32'h0);
    `CHK(rd, 32'h4)
    eos();
    waitTake(c0 + 3, 1'b1);
    `CHK(takenVec, 8'h30)
    eos();
    $display("priority test done");
    stall <= 1'b1;
    c0 = takenCnt;
    irq(8'h50, 1'b0);
    irq(8'h51, 1'b0);
    irq(8'h52, 1'b0);
    stall <= 1'b0;
    intOn <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK(takenCnt, c0)
    intOn <= 1'b1;
    waitTake(c0 + 1, 1'b1);
    `CHK(takenVec, 8'h51)
    eos();
    waitTake(c0 + 2, 1'b1);
    `CHK(takenVec, 8'h50)
    eos();
    `CHK(takenCnt, c0 + 2)
    $display("class depth test done");
    c0 = takenCnt;
    e0 = nEnd;
    bus(1'b1, `LIPU_OFF_CMDHI, 32'h0);
    bus(1'b1, `LIPU_OFF_CMDLO, 32'h00048066);
    waitTake(c0 + 1, 1'b1);
    `CHK(takenVec, 8'h66)
    eos();
    `CHK(nEnd, e0 + 1)
    bus(1'b1, `LIPU_OFF_CMDHI, 32'h05000000);
    bus(1'b1, `LIPU_OFF_CMDLO, 32'h00000077);
    waitTake(c0 + 2, 1'b0);
    `CHK(takenCnt, c0 + 1)
    bus(1'b1, `LIPU_OFF_CMDHI, 32'h00000000);
    bus(1'b1, `LIPU_OFF_CMDLO, 32'h0000007A);
    waitTake(c0 + 2, 1'b1);
    `CHK(takenVec, 8'h7A)
    eos();
    bus(1'b1, `LIPU_OFF_LTR, 32'h01000000);
    bus(1'b1, `LIPU_OFF_CMDHI, 32'h02000000);
    bus(1'b1, `LIPU_OFF_CMDLO, 32'h00000879);
    waitTake(c0 + 3, 1'b0);
    `CHK(takenCnt, c0 + 2)
    bus(1'b1, `LIPU_OFF_CMDHI, 32'h01000000);
    bus(1'b1, `LIPU_OFF_CMDLO, 32'h00000878);
    waitTake(c0 + 3, 1'b1);
    `CHK(takenVec, 8'h78)
    eos();
    bus(1'b1, `LIPU_OFF_CMDLO, 32'h00040005);
    bus(1'b0, `LIPU_OFF_ERR, 32'h0);
    `CHK(rd[`LIPU_ERR_SEND_BIT], 1'b1)
    $display("command test done");
    print_verdict();
  end
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule
